// ---- rtl/sirq_slave.sv ----
// device end of the serial interrupt link: reports slots 1 to 15 (frames 2 to 16) and the management request
// Behaviour
// - quiet idle start: one low clock, then release
// - never start while the line is active
// - idle from stop to start, else active
// - host stretches start low, high, releases
// - quiet mode: level change forces a start if reportable
// - continuous mode: only host starts cycles
// - mode changes at stop; continuous after reset
// - stop width two quiet, three continuous
// - count three-clock frames from start rise
// - sample phase drives low for low level
// - recovery drives high after own low
// - turn-around phase always releases line
// - report lows whoever started the cycle
// - frame N sample at clock 3N-1
// - frame 3 shares interrupt 2 and management
// - frame 14 carries interrupt 13
// - enable bits gate management to frame, pin
// - host may idle before the next start
// - slave start four clocks after stop rise
// - line released and continuous under reset
// - drive and sample on rising clock edge
`timescale 1ns/100ps
module sirq_slave
   import sirq_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   sirq_link_if.slave link,
   input wire logic [15:0] irqLevel,
   input wire logic mgmtRequestN,
   input wire logic mgmtFrameEn,
   input wire logic mgmtPinEn,
   output logic mgmtRequestOutN,
   output logic quietMode,
   output logic cycleActive
);
   import sirq_pkg::*;
   `include "sirq_map.svh"

   // ======================================================================
   // state
   typedef struct packed {
      sirq_slv_e state;
      sirq_pos_s pos;
      logic [2:0] runLen;
      logic prevLine;
      logic [15:0] irqLatch;
      logic [15:0] reported;
      logic quiet;
      logic droveLow;
      logic lineOut;
      logic lineOeN;
      logic mgmtOutN;
   } sirq_slv_s;

   localparam sirq_slv_s SLV_RESET = '{
      state: SIRQ_S_IDLE,
      pos: '{frame: `SIRQ_PRE_FRAME, phase: SIRQ_TURN},
      runLen: 3'h0,
      prevLine: `SIRQ_LINE_IDLE,
      irqLatch: `SIRQ_LEVELS_IDLE,
      reported: `SIRQ_LEVELS_IDLE,
      quiet: 1'b0,
      droveLow: 1'b0,
      lineOut: `SIRQ_LINE_IDLE,
      lineOeN: 1'b1,
      mgmtOutN: 1'b1
   };

   sirq_slv_s s_ff;
   sirq_slv_s nxt_s;
   logic lineSync;
   logic lineRise;
   logic pending;
   logic [3:0] slot;

   // ======================================================================
   // line input; the sync delay is folded into the frame count below
   sirq_sync sirq_sync_inst (
      .clock(clock),
      .reset(reset),
      .pinIn(link.line),
      .pinSync(lineSync)
   );

   assign lineRise = lineSync & ~s_ff.prevLine;
   assign pending = |((s_ff.irqLatch ^ s_ff.reported) & `SIRQ_SLOT_VALID);

   // ======================================================================
   // next state
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.prevLine = lineSync;
      // latch levels each clock: one copy feeds change detection and slots
      nxt_s.irqLatch = irqLevel | 16'h0001;
      // management request shares frame 3 with interrupt 2
      nxt_s.irqLatch[`SIRQ_SLOT_MGMT] = irqLevel[`SIRQ_SLOT_MGMT]
         & (mgmtRequestN | ~mgmtFrameEn);
      nxt_s.mgmtOutN = mgmtRequestN | ~mgmtPinEn;
      if (!lineSync)
      begin
         if (s_ff.runLen != `SIRQ_RUN_MAX)
            nxt_s.runLen = 3'(s_ff.runLen + 3'h1);
      end
      else
         nxt_s.runLen = 3'h0;
      // default: line released, which also covers every turn-around phase
      nxt_s.lineOut = `SIRQ_LINE_IDLE;
      nxt_s.lineOeN = 1'b1;
      slot = 4'h0;
      unique case (s_ff.state)
         SIRQ_S_IDLE:
         begin
            if (!lineSync)
               nxt_s.state = SIRQ_S_START;
            else if (s_ff.quiet && pending)
            begin
               // reaching idle needs a seen stop rise, so this is two clocks after it
               nxt_s.state = SIRQ_S_KICK;
               nxt_s.lineOut = 1'b0;
               nxt_s.lineOeN = 1'b0;
            end
         end
         SIRQ_S_KICK:
            // one clock low only, released without driving high
            nxt_s.state = SIRQ_S_START;
         SIRQ_S_START:
         begin
            // a short low run is our own kick echoed before the host takes over
            if (lineRise && s_ff.runLen >= `SIRQ_START_MIN_RUN)
            begin
               // synced rise arrives on clock 2, so next clock is frame 1 recovery
               nxt_s.state = SIRQ_S_FRAMES;
               nxt_s.pos = '{frame: `SIRQ_FIRST_FRAME, phase: SIRQ_RECOVER};
               nxt_s.droveLow = 1'b0;
            end
         end
         SIRQ_S_FRAMES:
         begin
            if (s_ff.pos.phase == SIRQ_TURN && s_ff.pos.frame == `SIRQ_LAST_SLAVE_FRAME)
               nxt_s.state = SIRQ_S_STOP;
            else
            begin
               nxt_s.pos = sirq_step(s_ff.pos);
               // frame N carries slot N-1, sampled on clock 3N-1
               slot = 4'(nxt_s.pos.frame - 5'h1);
               unique case (nxt_s.pos.phase)
                  SIRQ_SAMPLE:
                  begin
                     nxt_s.reported[slot] = s_ff.irqLatch[slot];
                     nxt_s.droveLow = ~s_ff.irqLatch[slot];
                     if (!s_ff.irqLatch[slot])
                     begin
                        nxt_s.lineOut = 1'b0;
                        nxt_s.lineOeN = 1'b0;
                     end
                  end
                  SIRQ_RECOVER:
                  begin
                     if (s_ff.droveLow)
                     begin
                        nxt_s.lineOut = 1'b1;
                        nxt_s.lineOeN = 1'b0;
                     end
                     nxt_s.droveLow = 1'b0;
                  end
                  SIRQ_TURN:
                     nxt_s.droveLow = 1'b0;
               endcase
            end
         end
         SIRQ_S_STOP:
         begin
            // other agents' single-clock slot lows never form a stop width
            if (lineRise)
            begin
               if (s_ff.runLen == `SIRQ_STOP_QUIET)
               begin
                  nxt_s.quiet = 1'b1;
                  nxt_s.state = SIRQ_S_IDLE;
               end
               else if (s_ff.runLen == `SIRQ_STOP_CONT)
               begin
                  nxt_s.quiet = 1'b0;
                  nxt_s.state = SIRQ_S_IDLE;
               end
            end
         end
      endcase
   end

   // ======================================================================
   // registers; reset releases the line and selects continuous mode
   always_ff @(posedge clock)
   begin
      if (reset)
         s_ff <= SLV_RESET;
      else
         s_ff <= nxt_s;
   end

   // ======================================================================
   // outputs
   assign link.slaveOut = s_ff.lineOut;
   assign link.slaveOeN = s_ff.lineOeN;
   assign mgmtRequestOutN = s_ff.mgmtOutN;
   assign quietMode = s_ff.quiet;
   assign cycleActive = (s_ff.state != SIRQ_S_IDLE);
endmodule // sirq_slave

// ---- rtl/sirq_map.svh ----
// named offsets, slot numbers, widths and reset values of the serial interrupt link
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH

// ==========================================================================
// frame layout
`define SIRQ_LAST_SLAVE_FRAME 5'h10
`define SIRQ_HOST_FRAMES 5'h11
`define SIRQ_FIRST_FRAME 5'h01
`define SIRQ_PRE_FRAME 5'h00
`define SIRQ_SLOT_MGMT 2
`define SIRQ_SLOT_IRQ13 13
`define SIRQ_SLOT_VALID 16'hfffe

// ==========================================================================
// pulse widths in clocks
`define SIRQ_START_MIN_RUN 3'h3
`define SIRQ_STOP_QUIET 3'h2
`define SIRQ_STOP_CONT 3'h3
`define SIRQ_RUN_MAX 3'h7
`define SIRQ_START_LOW_DEF 3'h3

// ==========================================================================
// reset values
`define SIRQ_LEVELS_IDLE 16'hffff
`define SIRQ_LINE_IDLE 1'h1

`endif

// ---- rtl/sirq_pkg.sv ----
// types and the frame stepping function shared by both ends
package sirq_pkg;

   // ======================================================================
   // frame phases, gray along sample, recovery, turn-around
   typedef enum logic [1:0] {
      SIRQ_SAMPLE = 2'h0,
      SIRQ_RECOVER = 2'h1,
      SIRQ_TURN = 2'h3
   } sirq_phase_e;

   typedef struct packed {
      logic [4:0] frame;
      sirq_phase_e phase;
   } sirq_pos_s;

   typedef enum logic [2:0] {
      SIRQ_S_IDLE = 3'h0,
      SIRQ_S_KICK = 3'h1,
      SIRQ_S_START = 3'h3,
      SIRQ_S_FRAMES = 3'h2,
      SIRQ_S_STOP = 3'h6
   } sirq_slv_e;

   typedef enum logic [2:0] {
      SIRQ_H_IDLE = 3'h0,
      SIRQ_H_START_LOW = 3'h1,
      SIRQ_H_START_HIGH = 3'h3,
      SIRQ_H_FRAMES = 3'h2,
      SIRQ_H_STOP_LOW = 3'h6,
      SIRQ_H_STOP_HIGH = 3'h7,
      SIRQ_H_STOP_TURN = 3'h5
   } sirq_hst_e;

   // ======================================================================
   // one clock further along the frame sequence
   function automatic sirq_pos_s sirq_step(input sirq_pos_s p);
      sirq_pos_s r;
      r = p;
      unique case (p.phase)
         SIRQ_SAMPLE: r.phase = SIRQ_RECOVER;
         SIRQ_RECOVER: r.phase = SIRQ_TURN;
         SIRQ_TURN:
         begin
            r.phase = SIRQ_SAMPLE;
            r.frame = 5'(p.frame + 5'h1);
         end
      endcase
      return r;
   endfunction

endpackage

// ---- rtl/sirq_link_if.sv ----
// the shared interrupt line: each end gives level and enable, the wire resolves them
`timescale 1ns/100ps
interface sirq_link_if;
   logic hostOut;
   logic hostOeN;
   logic slaveOut;
   logic slaveOeN;
   logic line;

   // undriven line floats high through the pull-up
   assign line = !hostOeN ? hostOut : (!slaveOeN ? slaveOut : 1'b1);

   modport host (output hostOut, output hostOeN, input line);
   modport slave (output slaveOut, output slaveOeN, input line);
endinterface

// ---- rtl/sirq_sync.sv ----
// two flip-flop synchroniser for the shared line, resets to the idle level
`timescale 1ns/100ps
module sirq_sync
   import sirq_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic pinIn,
   output logic pinSync
);
   `include "sirq_map.svh"

   typedef struct packed {
      logic first;
      logic second;
   } sirq_sync_s;

   sirq_sync_s s_ff;
   sirq_sync_s nxt_s;

   always_comb
   begin
      nxt_s.first = pinIn;
      nxt_s.second = s_ff.first;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         s_ff <= '{first: `SIRQ_LINE_IDLE, second: `SIRQ_LINE_IDLE};
      else
         s_ff <= nxt_s;
   end

   assign pinSync = s_ff.second;
endmodule // sirq_sync

// ---- rtl/sirq_host.sv ----
// host end of the serial interrupt link: runs cycles and collects slot levels
`timescale 1ns/100ps
// the frame count default below needs the map before the header
`include "sirq_map.svh"
module sirq_host
   import sirq_pkg::*;
#(
   parameter logic [4:0] FRAME_COUNT = `SIRQ_HOST_FRAMES
)
(
   input wire logic clock,
   input wire logic reset,
   sirq_link_if.host link,
   input wire logic startReq,
   input wire logic contRun,
   input wire logic quietReq,
   input wire logic [2:0] startLowClocks,
   output logic [15:0] irqState,
   output logic cycleDone,
   output logic quietMode,
   output logic busy
);
   import sirq_pkg::*;

   // ======================================================================
   // state
   typedef struct packed {
      sirq_hst_e state;
      sirq_pos_s pos;
      logic [3:0] cnt;
      logic quiet;
      logic lineOut;
      logic lineOeN;
      logic [15:0] irqState;
      logic done;
   } sirq_hst_s;

   localparam sirq_hst_s HST_RESET = '{
      state: SIRQ_H_IDLE,
      pos: '{frame: `SIRQ_PRE_FRAME, phase: SIRQ_TURN},
      cnt: 4'h0,
      quiet: 1'b0,
      lineOut: `SIRQ_LINE_IDLE,
      lineOeN: 1'b1,
      irqState: `SIRQ_LEVELS_IDLE,
      done: 1'b0
   };

   sirq_hst_s s_ff;
   sirq_hst_s nxt_s;
   logic lineSync;

   sirq_sync sirq_sync_inst (
      .clock(clock),
      .reset(reset),
      .pinIn(link.line),
      .pinSync(lineSync)
   );

   // ======================================================================
   // next state
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.lineOut = `SIRQ_LINE_IDLE;
      nxt_s.lineOeN = 1'b1;
      nxt_s.done = 1'b0;
      unique case (s_ff.state)
         SIRQ_H_IDLE:
         begin
            if (startReq)
            begin
               nxt_s.state = SIRQ_H_START_LOW;
               nxt_s.cnt = 4'({1'b0, startLowClocks} + 4'h1);
               nxt_s.lineOut = 1'b0;
               nxt_s.lineOeN = 1'b0;
            end
            else if (s_ff.quiet && !lineSync)
            begin
               // slave kick seen late through the sync; host adds startLowClocks, one clock fewer than its own start
               nxt_s.state = SIRQ_H_START_LOW;
               nxt_s.cnt = {1'b0, startLowClocks};
               nxt_s.lineOut = 1'b0;
               nxt_s.lineOeN = 1'b0;
            end
         end
         SIRQ_H_START_LOW, SIRQ_H_STOP_LOW:
         begin
            nxt_s.lineOeN = 1'b0;
            if (s_ff.cnt == 4'h1)
            begin
               // one high clock, then release in the next state
               nxt_s.state = (s_ff.state == SIRQ_H_START_LOW) ? SIRQ_H_START_HIGH
                  : SIRQ_H_STOP_HIGH;
               nxt_s.lineOut = 1'b1;
            end
            else
            begin
               nxt_s.cnt = 4'(s_ff.cnt - 4'h1);
               nxt_s.lineOut = 1'b0;
            end
         end
         SIRQ_H_START_HIGH:
         begin
            // this clock is clock 0 after the rise
            nxt_s.state = SIRQ_H_FRAMES;
            nxt_s.pos = '{frame: `SIRQ_PRE_FRAME, phase: SIRQ_TURN};
         end
         SIRQ_H_FRAMES:
         begin
            // turn-around of frame N sees its sample clock through the sync
            if (s_ff.pos.phase == SIRQ_TURN && s_ff.pos.frame != `SIRQ_PRE_FRAME
               && s_ff.pos.frame <= `SIRQ_LAST_SLAVE_FRAME)
               nxt_s.irqState[4'(s_ff.pos.frame - 5'h1)] = lineSync;
            if (s_ff.pos.phase == SIRQ_TURN && s_ff.pos.frame == FRAME_COUNT)
            begin
               nxt_s.state = SIRQ_H_STOP_LOW;
               nxt_s.quiet = quietReq;
               nxt_s.cnt = {1'b0, quietReq ? `SIRQ_STOP_QUIET : `SIRQ_STOP_CONT};
               nxt_s.lineOut = 1'b0;
               nxt_s.lineOeN = 1'b0;
            end
            else
               nxt_s.pos = sirq_step(s_ff.pos);
         end
         SIRQ_H_STOP_HIGH:
         begin
            nxt_s.state = SIRQ_H_STOP_TURN;
            nxt_s.done = 1'b1;
         end
         SIRQ_H_STOP_TURN:
         begin
            if (!s_ff.quiet && contRun)
            begin
               nxt_s.state = SIRQ_H_START_LOW;
               nxt_s.cnt = 4'({1'b0, startLowClocks} + 4'h1);
               nxt_s.lineOut = 1'b0;
               nxt_s.lineOeN = 1'b0;
            end
            else
               nxt_s.state = SIRQ_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         s_ff <= HST_RESET;
      else
         s_ff <= nxt_s;
   end

   // ======================================================================
   // outputs
   assign link.hostOut = s_ff.lineOut;
   assign link.hostOeN = s_ff.lineOeN;
   assign irqState = s_ff.irqState;
   assign cycleDone = s_ff.done;
   assign quietMode = s_ff.quiet;
   assign busy = (s_ff.state != SIRQ_H_IDLE);
endmodule // sirq_host

// ---- verification/sirq_link_asserts.sv ----
// concurrent checks on the shared interrupt line between the host and slave ends
`timescale 1ns/100ps
module sirq_link_asserts
(
   input wire logic clock,
   input wire logic reset,
   input wire logic hostOut,
   input wire logic hostOeN,
   input wire logic slaveOut,
   input wire logic slaveOeN,
   input wire logic line
);
   // ==========================================================
   // cycle tracking from what the host drives
   logic [3:0] lowRun_ff;
   logic [3:0] nxt_lowRun;
   logic [5:0] slotPos_ff;
   logic [5:0] nxt_slotPos;
   logic active_ff;
   logic nxt_active;
   logic hostHigh;
   logic slaveLow;

   assign hostHigh = !hostOeN && hostOut;
   assign slaveLow = !slaveOeN && !slaveOut;

   // start and stop both end in a host high clock; being active tells them apart,
   // since a start after a slave kick may show only three host low clocks
   always_comb
   begin
      nxt_lowRun = (!hostOeN && !hostOut) ? lowRun_ff + {3'h0, lowRun_ff != 4'hf} : 4'h0;
      nxt_active = active_ff;
      nxt_slotPos = (slotPos_ff == 6'h3f) ? slotPos_ff : slotPos_ff + 6'h1;
      if (hostHigh && active_ff)
         nxt_active = 1'b0;
      else if (hostHigh && lowRun_ff >= 4'h3)
      begin
         nxt_active = 1'b1;
         nxt_slotPos = 6'h1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         lowRun_ff <= 4'h0;
         slotPos_ff <= 6'h3f;
         active_ff <= 1'b0;
      end
      else
      begin
         lowRun_ff <= nxt_lowRun;
         slotPos_ff <= nxt_slotPos;
         active_ff <= nxt_active;
      end
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   property p_reset_release;
      $fell(reset) |-> hostOeN && slaveOeN;
   endproperty
   a_reset_release: assert property (p_reset_release)
      else $error("line driven at reset release");

   property p_low_one_clock;
      slaveLow |=> slaveOeN || slaveOut;
   endproperty
   a_low_one_clock: assert property (p_low_one_clock)
      else $error("slave low for two clocks");

   property p_high_after_low;
      !slaveOeN && slaveOut |-> !$past(slaveOeN) && !$past(slaveOut);
   endproperty
   a_high_after_low: assert property (p_high_after_low)
      else $error("slave high without own low before");

   property p_turn_release;
      !slaveOeN && slaveOut |=> slaveOeN;
   endproperty
   a_turn_release: assert property (p_turn_release)
      else $error("slave kept line in turn-around");

   property p_slot_position;
      slaveLow && active_ff |->
         slotPos_ff >= 6'h05 && slotPos_ff <= 6'h2f && slotPos_ff % 6'h3 == 6'h2;
   endproperty
   a_slot_position: assert property (p_slot_position)
      else $error("slave low outside a sample clock");

   property p_kick_release;
      slaveLow && !active_ff |=> slaveOeN;
   endproperty
   a_kick_release: assert property (p_kick_release)
      else $error("slave start not released after one clock");

   property p_kick_after_stop;
      slaveLow && !active_ff |-> $past(line) && $past(line, 2);
   endproperty
   a_kick_after_stop: assert property (p_kick_after_stop)
      else $error("slave start too soon");

   property p_host_high_release;
      hostHigh |=> hostOeN;
   endproperty
   a_host_high_release: assert property (p_host_high_release)
      else $error("host high longer than one clock");

   property p_no_clash;
      !hostOeN |-> slaveOeN;
   endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drive the line");
endmodule // sirq_link_asserts

// ---- verification/serial_irq_slave_agent_test.sv ----
// self-checking bench joining the host and slave ends over the shared line
`timescale 1ns/100ps
module serial_irq_slave_agent_test;
   import sirq_pkg::*;

   // mgmt holds request level, frame enable, pin enable
   typedef struct {
      logic [15:0] lvl;
      logic [2:0] mgmt;
      logic [2:0] low;
      logic quiet;
      logic [15:0] expState;
      logic expPinN;
   } sirq_row_s;

   logic clock, reset, startReq, contRun, quietReq, mgmtRequestN, mgmtFrameEn, mgmtPinEn;
   logic cycleDone, hostQuiet, busy, mgmtRequestOutN, slaveQuiet, cycleActive;
   logic sawActive, sawDrive;
   logic [2:0] startLowClocks;
   logic [15:0] irqLevel, irqState;
   int fail_count, check_count;
   bit seen;
   sirq_row_s rows[6] = '{
      '{16'hffff, 3'h7, 3'h3, 1'h0, 16'hffff, 1'h1},
      '{16'hdfdd, 3'h4, 3'h4, 1'h0, 16'hdfdd, 1'h1},
      '{16'hffff, 3'h3, 3'h5, 1'h0, 16'hfffb, 1'h0},
      '{16'hffff, 3'h0, 3'h6, 1'h0, 16'hffff, 1'h1},
      '{16'h0000, 3'h6, 3'h7, 1'h0, 16'h0001, 1'h1},
      '{16'h7ffe, 3'h5, 3'h3, 1'h1, 16'h7fff, 1'h1}};

   sirq_link_if link();
   sirq_host sirq_host_inst (.clock(clock), .reset(reset), .link(link), .startReq(startReq),
      .contRun(contRun), .quietReq(quietReq), .startLowClocks(startLowClocks),
      .irqState(irqState), .cycleDone(cycleDone), .quietMode(hostQuiet), .busy(busy));
   sirq_slave sirq_slave_inst (.clock(clock), .reset(reset), .link(link), .irqLevel(irqLevel),
      .mgmtRequestN(mgmtRequestN), .mgmtFrameEn(mgmtFrameEn), .mgmtPinEn(mgmtPinEn),
      .mgmtRequestOutN(mgmtRequestOutN), .quietMode(slaveQuiet), .cycleActive(cycleActive));
   sirq_link_asserts sirq_link_asserts_inst (.clock(clock), .reset(reset),
      .hostOut(link.hostOut), .hostOeN(link.hostOeN), .slaveOut(link.slaveOut),
      .slaveOeN(link.slaveOeN), .line(link.line));

   always #50 clock = ~clock;

   // looked at mid-cycle, where the registered outputs have settled
   always @(negedge clock)
   begin
      if (cycleActive === 1'b1)
         sawActive = 1'b1;
      if (link.slaveOeN === 1'b0)
         sawDrive = 1'b1;
   end

   // ==========================================================
   // shared tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("MISMATCH at %0t: got 0x%h expected 0x%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // a missing cycle end where one is due ends the run at once
   task automatic wait_done(input int bound, input bit must, output bit got);
      got = 1'b0;
      for (int i = 0; i < bound && !got; i++)
      begin
         @(negedge clock);
         got = (cycleDone === 1'b1);
      end
      if (must && !got)
      begin
         $display("MISMATCH at %0t: got 0x0 expected 0x1", $time);
         fail_count++;
         end_sim();
      end
   endtask

   task automatic run_cycle(input logic [2:0] low, input logic quiet);
      startLowClocks = low;
      quietReq = quiet;
      startReq = 1'b1;
      @(negedge clock);
      startReq = 1'b0;
      wait_done(300, 1'b1, seen);
      repeat (4) @(negedge clock);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      clock = 1'b0;
      reset = 1'b1;
      {startReq, contRun, quietReq} = 3'h0;
      {mgmtRequestN, mgmtFrameEn, mgmtPinEn} = 3'h7;
      startLowClocks = 3'h3;
      irqLevel = 16'hffff;
      {sawActive, sawDrive} = 2'h0;
      repeat (20) @(negedge clock);
      reset = 1'b0;
      @(negedge clock);
      check({14'h0, hostQuiet, slaveQuiet}, 16'h0);
      check(irqState, 16'hffff);
      $display("reset test done");
      for (int r = 0; r < 6; r++)
      begin
         irqLevel = rows[r].lvl;
         {mgmtRequestN, mgmtFrameEn, mgmtPinEn} = rows[r].mgmt;
         run_cycle(rows[r].low, rows[r].quiet);
         check(irqState, rows[r].expState);
         check({15'h0, mgmtRequestOutN}, {15'h0, rows[r].expPinN});
         check({14'h0, hostQuiet, slaveQuiet}, {14'h0, rows[r].quiet, rows[r].quiet});
         $display("row %0d test done", r);
      end
      // quiet mode: a level change alone must bring a cycle
      sawActive = 1'b0;
      irqLevel = 16'h7fde;
      wait_done(300, 1'b1, seen);
      check(irqState, 16'h7fdf);
      check({15'h0, sawActive}, 16'h1);
      repeat (4) @(negedge clock);
      wait_done(150, 1'b0, seen);
      check({15'h0, seen}, 16'h0);
      $display("quiet start test done");
      // back to continuous: changes must stay unreported until the host starts
      run_cycle(3'h3, 1'b0);
      check({14'h0, hostQuiet, slaveQuiet}, 16'h0);
      sawDrive = 1'b0;
      irqLevel = 16'hbffe;
      wait_done(150, 1'b0, seen);
      check({13'h0, seen, sawDrive, busy}, 16'h0);
      $display("continuous test done");
      // back-to-back cycles: the second must open with no new request
      contRun = 1'b1;
      startReq = 1'b1;
      @(negedge clock);
      startReq = 1'b0;
      wait_done(300, 1'b1, seen);
      wait_done(100, 1'b1, seen);
      contRun = 1'b0;
      repeat (4) @(negedge clock);
      check({15'h0, busy}, 16'h0);
      check(irqState, 16'hbfff);
      $display("restart test done");
      // reset in mid-cycle, then the host must open the next cycle
      startReq = 1'b1;
      @(negedge clock);
      startReq = 1'b0;
      repeat (20) @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      check({12'h0, link.hostOeN, link.slaveOeN, hostQuiet, slaveQuiet}, 16'hc);
      check(irqState, 16'hffff);
      reset = 1'b0;
      @(negedge clock);
      run_cycle(3'h7, 1'b0);
      check(irqState, 16'hbfff);
      $display("mid-cycle reset test done");
      end_sim();
   end
endmodule // serial_irq_slave_agent_test
